// ### design/adc_host_pkg.sv
package adc_host_pkg;

    // timing figures in their own units, cycle counts derived at 10 MHz
    localparam int CLK_PERIOD_NS         = 100;
    localparam int START_MIN_NS          = 500;
    localparam int START_TYPICAL_MIN_NS  = 300;
    localparam int BUFFER_ACCESS_MAX_NS  = 250;
    localparam int STANDALONE_VALID_NS   = 500;
    localparam int CONVERSION_MAX_US     = 30;
    localparam int DONE_RISE_MAX_US      = 2;

    localparam int START_MIN_CYC   = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC      = (BUFFER_ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VALID_CYC       = (STANDALONE_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_WAIT_CYC   = (CONVERSION_MAX_US * 1000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int DONE_RISE_CYC   = DONE_RISE_MAX_US * 1000 / CLK_PERIOD_NS;

    localparam int RESULT_W        = 10;
    localparam int BYTE_W          = 8;
    localparam logic [7:0] LOW_BYTE_MASK = 8'hC0;
    localparam int CNT_W           = 12;

    // host command port
    typedef struct packed {
        logic       start;
        logic       read_high;
        logic       read_low;
        logic       read_word;
        logic       use_done;
        logic       standalone;
    } cmd_s;

    typedef struct packed {
        logic                 done;
        logic [RESULT_W-1:0]  result;
        logic [BYTE_W-1:0]    byte_data;
        logic                 busy;
        logic                 timeout;
    } rsp_s;

    // converter pins seen from the host
    typedef struct packed {
        logic convert;
        logic upper_byte_output_enable_n;
        logic lower_byte_output_enable_n;
    } pins_out_s;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_START   = 3'b001,
        ST_RELEASE = 3'b010,
        ST_CONVERT = 3'b011,
        ST_READ    = 3'b100,
        ST_SETTLE  = 3'b101
    } state_e;

    typedef enum logic [1:0] {
        RD_HIGH = 2'b00,
        RD_LOW  = 2'b01,
        RD_WORD = 2'b10
    } read_kind_e;

endpackage

// ### design/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    // clock
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // pins
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } state_s;

    state_s st_reg;
    state_s st_next;

    always_comb
    begin
        st_next = st_reg;
        if (ce_i)
        begin
            st_next.meta = async_i;
            st_next.sync = st_reg.meta;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            st_reg <= '{meta: '1, sync: '1};
        else
            st_reg <= st_next;
    end

    assign sync_o = st_reg.sync;

endmodule

// ### design/adc_host_ctrl.sv
`timescale 1ns/1ns
// How it works
// RL1 - start pulse held high at least 500 ns
// RL2 - start stays high until done rises; the code releases it after DONE_RISE_CYC cycles if done stays low
// RL3 - converter raises done after internal reset
// RL4 - start width varies with previous lsb
// RL5 - result arrives left justified
// RL6 - upper enable eight msbs, lower two lsbs
// RL7 - low byte lower six bits are junk
// RL8 - host masks low byte with C0
// RL9 - no right justify option in converter
// RL10 - both enables together read ten bits
// RL11 - stand-alone: done drives enables, 500 ns valid
// RL12 - read strobe stretched past 250 ns access
// RL13 - host waits before reading after start
// RL14 - start rise resets, fall begins conversion
// RL15 - enables held high during conversion
// RL16 - without done, wait 30 us before reading
// RL17 - write base starts; reads base, base+1
// RL18 - result stable until next start rise
module adc_host_ctrl
    import adc_host_pkg::*;
#(
    parameter int CONV_WAIT = adc_host_pkg::CONV_WAIT_CYC
) (
    // clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_i,
    input  wire logic                        ce_i,
    // host command port
    input  wire adc_host_pkg::cmd_s          cmd_i,
    input  wire logic                        addr_i,
    output adc_host_pkg::rsp_s               rsp_o,
    // converter pins
    output adc_host_pkg::pins_out_s          pins_o,
    input  wire logic                        conversion_done_n_i,
    input  wire logic [15:0]                 data_i
);
    import adc_host_pkg::*;

    typedef struct packed {
        state_e               state;
        read_kind_e           kind;
        logic [CNT_W-1:0]     cnt;
        logic [CNT_W-1:0]     wait_cnt;
        logic                 done_prev;
        logic                 use_done;
        logic                 standalone;
        pins_out_s            pins;
        rsp_s                 rsp;
    } state_s;

    state_s     st_reg;
    state_s     st_next;
    logic [16:0] pins_sync;
    logic        done_n_s;
    logic [15:0] data_s;

    // pins are asynchronous to the host clock
    pin_sync #(
        .W (17)
    ) pin_sync_inst (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .async_i   ({conversion_done_n_i, data_i}),
        .sync_o    (pins_sync[16:0])
    );
    assign done_n_s      = pins_sync[16];
    assign data_s        = pins_sync[15:0];

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n);
    endfunction

    always_comb
    begin
        st_next = st_reg;
        st_next.rsp.done = 1'b0;
        if (ce_i)
        begin
            st_next.done_prev = done_n_s;
            unique case (st_reg.state)
                ST_IDLE:
                begin
                    st_next.rsp.busy = 1'b0;
                    if (cmd_i.start && !addr_i)                         // RL17
                    begin
                        st_next.state         = ST_START;
                        st_next.pins.convert  = 1'b1;                   // RL2
                        st_next.cnt           = '0;
                        st_next.use_done      = cmd_i.use_done;
                        st_next.standalone    = cmd_i.standalone;
                        st_next.rsp.busy      = 1'b1;
                        st_next.rsp.timeout   = 1'b0;
                    end
                    else if (cmd_i.read_word)                          // RL10
                    begin
                        st_next.state = ST_READ;
                        st_next.kind  = RD_WORD;
                        st_next.cnt   = '0;
                        st_next.pins.upper_byte_output_enable_n = 1'b0;
                        st_next.pins.lower_byte_output_enable_n = 1'b0;
                        st_next.rsp.busy = 1'b1;
                    end
                    else if (cmd_i.read_high || cmd_i.read_low)
                    begin
                        // read_low or base+1 picks the low byte; read_high at base picks high
                        st_next.state = ST_READ;
                        st_next.kind  = (cmd_i.read_low || addr_i) ? RD_LOW : RD_HIGH; // RL17
                        st_next.cnt   = '0;
                        if (cmd_i.read_low || addr_i)
                            st_next.pins.lower_byte_output_enable_n = 1'b0; // RL6
                        else
                            st_next.pins.upper_byte_output_enable_n = 1'b0; // RL6
                        st_next.rsp.busy = 1'b1;
                    end
                end
                ST_START:
                begin
                    // hold convert until min width and done rising edge or done high, releasing anyway after DONE_RISE_CYC
                    st_next.cnt = st_reg.cnt + 1'b1;
                    if (!st_reg.done_prev && done_n_s)
                        st_next.state = ST_RELEASE;                     // RL3
                    else if (done_n_s && st_reg.cnt >= cyc(START_MIN_CYC - 1))
                        st_next.state = ST_RELEASE;
                    else if (st_reg.cnt >= cyc(DONE_RISE_CYC))
                        st_next.state = ST_RELEASE;                     // RL4
                end
                ST_RELEASE:
                begin
                    st_next.cnt = st_reg.cnt + 1'b1;
                    if (st_reg.cnt >= cyc(START_MIN_CYC - 1))          // RL1
                    begin
                        st_next.pins.convert = 1'b0;                    // RL14
                        st_next.state        = ST_CONVERT;
                        st_next.wait_cnt     = '0;
                    end
                end
                ST_CONVERT:
                begin
                    // enables stay high the whole conversion
                    st_next.wait_cnt = st_reg.wait_cnt + 1'b1;         // RL15
                    if (st_reg.use_done || st_reg.standalone)
                    begin
                        if (!done_n_s)
                        begin
                            if (st_reg.standalone)
                            begin
                                st_next.pins.upper_byte_output_enable_n = 1'b0; // RL11
                                st_next.pins.lower_byte_output_enable_n = 1'b0;
                                st_next.kind  = RD_WORD;
                                st_next.state = ST_SETTLE;
                                st_next.cnt   = '0;
                            end
                            else
                            begin
                                st_next.state    = ST_IDLE;
                                st_next.rsp.done = 1'b1;
                                st_next.rsp.busy = 1'b0;
                            end
                        end
                        else if (st_reg.wait_cnt >= cyc(CONV_WAIT - 1))
                        begin
                            // done never fell: give up rather than hang
                            st_next.state       = ST_IDLE;
                            st_next.rsp.timeout = 1'b1;
                            st_next.rsp.done    = 1'b1;
                            st_next.rsp.busy    = 1'b0;
                        end
                    end
                    else if (st_reg.wait_cnt >= cyc(CONV_WAIT - 1))    // RL16 RL13
                    begin
                        st_next.state    = ST_IDLE;
                        st_next.rsp.done = 1'b1;
                        st_next.rsp.busy = 1'b0;
                    end
                end
                ST_SETTLE:
                begin
                    st_next.cnt = st_reg.cnt + 1'b1;
                    // extra two cycles cover the pin synchroniser
                    if (st_reg.cnt >= cyc(VALID_CYC + 1))               // RL11
                    begin
                        st_next.rsp.result    = data_s[15:6];           // RL5
                        st_next.rsp.byte_data = data_s[15:8];
                        st_next.pins.upper_byte_output_enable_n = 1'b1;
                        st_next.pins.lower_byte_output_enable_n = 1'b1;
                        st_next.state    = ST_IDLE;
                        st_next.rsp.done = 1'b1;
                        st_next.rsp.busy = 1'b0;
                    end
                end
                ST_READ:
                begin
                    // stretched strobe: access time plus synchroniser delay
                    st_next.cnt = st_reg.cnt + 1'b1;
                    if (st_reg.cnt >= cyc(ACCESS_CYC + 1))             // RL12
                    begin
                        unique case (st_reg.kind)
                            RD_HIGH:
                            begin
                                st_next.rsp.byte_data = data_s[15:8];  // RL6
                                st_next.rsp.result    = {data_s[15:8],
                                                         st_reg.rsp.result[1:0]};
                            end
                            RD_LOW:
                            begin
                                // only the top two lines carry bits one and zero
                                st_next.rsp.byte_data = data_s[15:8] & LOW_BYTE_MASK; // RL7 RL8
                                st_next.rsp.result    = {st_reg.rsp.result[9:2],
                                                         data_s[15:14]};
                            end
                            default:
                            begin
                                // left justified word at the high end of the bus
                                st_next.rsp.result    = data_s[15:6];   // RL5 RL9 RL10
                                st_next.rsp.byte_data = data_s[15:8];
                            end
                        endcase
                        st_next.pins.upper_byte_output_enable_n = 1'b1;
                        st_next.pins.lower_byte_output_enable_n = 1'b1;
                        st_next.state    = ST_IDLE;
                        st_next.rsp.done = 1'b1;
                        st_next.rsp.busy = 1'b0;
                    end
                end
                default:
                    st_next.state = ST_IDLE;
            endcase
        end
        else
            st_next.rsp.done = st_reg.rsp.done;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
            st_reg.state <= ST_IDLE;
            st_reg.kind <= RD_HIGH;
            st_reg.done_prev <= 1'b1;
            st_reg.pins <= '{convert: 1'b0,
                             upper_byte_output_enable_n: 1'b1,
                             lower_byte_output_enable_n: 1'b1};
        end
        else
            st_reg <= st_next;
    end

    assign rsp_o  = st_reg.rsp;
    assign pins_o = st_reg.pins;

endmodule

// ### verif/adc_host_ctrl_monitor.sv
`timescale 1ns/1ns
module adc_host_ctrl_monitor
    import adc_host_pkg::*;
#(
    parameter int CONV_WAIT = 300
) (
    // clock and reset
    input wire logic                    clk_sys_i,
    input wire logic                    rst_i,
    input wire logic                    ce_i,
    // host side
    input wire adc_host_pkg::cmd_s      cmd_i,
    input wire logic                    addr_i,
    input wire adc_host_pkg::rsp_s      rsp_o,
    // converter side
    input wire adc_host_pkg::pins_out_s pins_o,
    input wire logic                    conversion_done_n_i,
    input wire logic [15:0]             data_i
);
    // count restarts while convert is high, so it spans the whole wait
    localparam int MIN_GAP = CONV_WAIT;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic        idle;
    logic        timed_reg;
    logic [15:0] since_reg;
    assign idle = ce_i && !rsp_o.busy;
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || rsp_o.done)
            timed_reg <= 1'b0;
        else if (idle && cmd_i.start && !addr_i)
            timed_reg <= !cmd_i.use_done && !cmd_i.standalone;
        if (rst_i || pins_o.convert)
            since_reg <= 16'h0000;
        else if (since_reg != 16'hFFFF)
            since_reg <= since_reg + 16'h0001;
    end
    a_start_min_width: assert property ($rose(pins_o.convert) |-> pins_o.convert[*5])
        else $error("start pulse too short");
    a_start_release: assert property (pins_o.convert && $rose(conversion_done_n_i)
        |-> ##[1:6] !pins_o.convert) else $error("start not released after done rise");
    a_low_mask: assert property ($rose(pins_o.lower_byte_output_enable_n)
        && $past(pins_o.upper_byte_output_enable_n) |-> rsp_o.byte_data[5:0] == 6'h00)
        else $error("low byte not masked");
    a_word_both_en: assert property (idle && cmd_i.read_word && !cmd_i.start
        |=> !pins_o.upper_byte_output_enable_n && !pins_o.lower_byte_output_enable_n)
        else $error("word read without both enables");
    a_read_hold: assert property ($fell(pins_o.upper_byte_output_enable_n)
        |-> !pins_o.upper_byte_output_enable_n[*5]) else $error("read strobe too short");
    a_quiet_convert: assert property (pins_o.convert |-> pins_o.upper_byte_output_enable_n
        && pins_o.lower_byte_output_enable_n) else $error("enable low during start");
    a_timed_wait: assert property (rsp_o.done && timed_reg |-> since_reg >= MIN_GAP)
        else $error("timed conversion ended early");
    a_base_starts: assert property (idle && cmd_i.start && !addr_i
        |=> pins_o.convert && rsp_o.busy) else $error("base write did not start");
    a_upper_ignored: assert property (idle && cmd_i.start && addr_i && !cmd_i.read_high
        && !cmd_i.read_low && !cmd_i.read_word |=> !rsp_o.busy)
        else $error("write to next address acted");
    cover property (rsp_o.done && timed_reg);
    cover property (!pins_o.upper_byte_output_enable_n && !pins_o.lower_byte_output_enable_n);
    cover property ($fell(pins_o.convert));
    cover property (rsp_o.done && rsp_o.timeout);
endmodule

// ### verif/adc_conv_model.sv
`timescale 1ns/1ns
module adc_conv_model
    import adc_host_pkg::*;
#(
    // off the 100 ns grid so done and the result never move on a clock edge
    parameter int START_TO_DONE_HIGH_DELAY_NS = 1030,
    parameter int CONV_NS                     = 1530
) (
    // host pins
    input  wire adc_host_pkg::pins_out_s pins_i,
    input  wire logic [9:0]              sample_i,
    input  wire logic                    hold_i,
    // converter outputs
    output logic                         conversion_done_n_o,
    output logic [15:0]                  data_o
);
    logic [9:0]  res_q = 10'h000;
    logic [15:0] junk_q = 16'hA5C3;
    initial conversion_done_n_o = 1'b0;
    // released lines wander so the simulator cannot settle them for us
    always #70 junk_q = {junk_q[14:0], junk_q[15] ^ junk_q[12]};
    always @(posedge pins_i.convert)
    begin
        #(res_q[0] ? START_TO_DONE_HIGH_DELAY_NS + 200 : START_TO_DONE_HIGH_DELAY_NS);
        res_q = 10'h000;
        conversion_done_n_o = 1'b1;
    end
    always @(negedge pins_i.convert)
    begin
        #(CONV_NS);
        // hold keeps done high, a converter that never finishes
        if (!hold_i)
        begin
            res_q = sample_i;
            conversion_done_n_o = 1'b0;
        end
    end
    always_comb
    begin
        data_o = junk_q;
        if (!pins_i.upper_byte_output_enable_n && !pins_i.lower_byte_output_enable_n)
            data_o[15:6] = res_q;
        else if (!pins_i.upper_byte_output_enable_n)
            data_o[15:8] = res_q[9:2];
        else if (!pins_i.lower_byte_output_enable_n)
            data_o[15:14] = res_q[1:0];
    end
endmodule

// ### verif/adc_host_ctrl_tb.sv
`timescale 1ns/1ns
module adc_host_ctrl_tb;
    import adc_host_pkg::*;
    localparam int   CONV_WAIT   = 20;
    localparam cmd_s START_TIMED = 6'h20;
    localparam cmd_s START_DONE  = 6'h22;
    localparam cmd_s START_ALONE = 6'h21;
    localparam cmd_s READ_HIGH   = 6'h10;
    localparam cmd_s READ_LOW    = 6'h08;
    localparam cmd_s READ_WORD   = 6'h04;
    logic        clk_sys_i;
    logic        rst_i;
    logic        ce;
    logic        hold;
    cmd_s        cmd_i;
    logic        addr_i;
    rsp_s        rsp_o;
    pins_out_s   pins_o;
    logic        done_n;
    logic [15:0] data_bus;
    logic [9:0]  sample;
    int          n_fail;
    int          cmp_count;
    adc_host_ctrl #(.CONV_WAIT(CONV_WAIT)) adc_host_ctrl_inst (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .ce_i(ce), .cmd_i(cmd_i), .addr_i(addr_i), .rsp_o(rsp_o),
        .pins_o(pins_o), .conversion_done_n_i(done_n), .data_i(data_bus));
    adc_conv_model adc_conv_model_inst (.pins_i(pins_o), .sample_i(sample),
        .hold_i(hold), .conversion_done_n_o(done_n), .data_o(data_bus));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic issue(input cmd_s c, input logic a);
        @(posedge clk_sys_i);
        #10;
        cmd_i = c;
        addr_i = a;
        @(posedge clk_sys_i);
        #10;
        cmd_i = 6'h00;
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        while (rsp_o.done !== 1'b1 && k < 400)
        begin
            @(posedge clk_sys_i);
            #1;
            k++;
        end
        check("done", 16'(rsp_o.done), 16'h0001);
    endtask
    task automatic t_timed();
        sample = 10'h2A7;
        issue(START_TIMED, 1'b0);
        issue(READ_WORD, 1'b0);
        wait_done();
        check("timeout", 16'(rsp_o.timeout), 16'h0000);
        issue(READ_WORD, 1'b0);
        wait_done();
        check("word", 16'(rsp_o.result), 16'h02A7);
    endtask
    task automatic t_bytes();
        sample = 10'h15A;
        issue(START_DONE, 1'b0);
        wait_done();
        issue(READ_LOW, 1'b0);
        wait_done();
        check("low byte", 16'(rsp_o.byte_data), 16'h0080);
        issue(READ_HIGH, 1'b0);
        wait_done();
        check("high byte", 16'(rsp_o.byte_data), 16'h0056);
        check("paired", 16'(rsp_o.result), 16'h015A);
    endtask
    task automatic t_ignored();
        issue(START_TIMED, 1'b1);
        check("next write", 16'(rsp_o.busy), 16'h0000);
        issue(READ_WORD, 1'b0);
        wait_done();
        check("held word", 16'(rsp_o.result), 16'h015A);
    endtask
    task automatic t_freeze();
        issue(READ_HIGH, 1'b1);
        ce = 1'b0;
        repeat (10) @(posedge clk_sys_i);
        #10;
        check("frozen busy", 16'(rsp_o.busy), 16'h0001);
        check("frozen pins", 16'(pins_o), 16'h0002);
        ce = 1'b1;
        wait_done();
        check("base+1 byte", 16'(rsp_o.byte_data), 16'h0080);
    endtask
    task automatic t_reset();
        sample = 10'h0F0;
        issue(START_TIMED, 1'b0);
        repeat (3) @(posedge clk_sys_i);
        #10;
        check("start pins", 16'(pins_o), 16'h0007);
        rst_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #10;
        check("reset pins", 16'(pins_o), 16'h0003);
        check("reset busy", 16'(rsp_o.busy), 16'h0000);
        check("reset result", 16'(rsp_o.result), 16'h0000);
        rst_i = 1'b0;
        // let the cut conversion in the model run out
        repeat (30) @(posedge clk_sys_i);
    endtask
    task automatic t_stall();
        hold = 1'b1;
        issue(START_DONE, 1'b0);
        wait_done();
        check("stalled", 16'(rsp_o.timeout), 16'h0001);
        hold = 1'b0;
    endtask
    task automatic t_alone();
        sample = 10'h3C1;
        issue(START_ALONE, 1'b0);
        wait_done();
        check("stand-alone", 16'(rsp_o.result), 16'h03C1);
        check("timeout cleared", 16'(rsp_o.timeout), 16'h0000);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        #1000000;
        n_fail++;
        print_verdict();
    end
    initial
    begin
        n_fail = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        ce = 1'b1;
        hold = 1'b0;
        cmd_i = 6'h00;
        addr_i = 1'b0;
        sample = 10'h001;
        repeat (20) @(posedge clk_sys_i);
        #10;
        rst_i = 1'b0;
        t_timed();
        t_bytes();
        t_ignored();
        t_freeze();
        t_reset();
        t_stall();
        t_alone();
        print_verdict();
    end
endmodule
bind adc_host_ctrl adc_host_ctrl_monitor #(.CONV_WAIT(CONV_WAIT)) adc_host_ctrl_monitor_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_i(cmd_i), .addr_i(addr_i),
    .rsp_o(rsp_o), .pins_o(pins_o), .conversion_done_n_i(conversion_done_n_i),
    .data_i(data_i));
